// File: logic/tw_exec.sv
// Table-write instruction execution: latch load, program write, pointer update
//
// Overview of operation
// RL1 - Increment bit clear: table pointer stays unchanged after the write.
// RL2 - Increment bit set: table pointer advances by one after the write.
// RL3 - One word, two instruction cycles; on-chip program writes last many cycles.
// RL4 - Without programming voltage the on-chip sequence runs but reports failure.
// RL5 - Read file register in Q2, execute in Q3, write in Q4.
// RL6 - Byte-select set loads latch high byte, clear loads low; other half kept.
`timescale 1ns/1ps
module tw_exec #(
  parameter int unsigned PROG_LEN = tw_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // Instruction issue from the core
  input  wire logic                       instr_valid,
  input  wire tw_pkg::tw_instr_type       instr,
  output logic                            instr_ready,
  output logic                            busy,
  output logic                            done,
  // Data memory read port
  output logic                            file_rd,
  output logic [tw_pkg::DATA_W-1:0]       file_addr,
  input  wire logic [tw_pkg::DATA_W-1:0]  file_data,
  // Program memory side
  input  wire logic                       prog_voltage_ok,
  input  wire logic                       irq_abort,
  output tw_pkg::tw_pm_req_type           pm_req,
  output logic                            prog_active,
  // Visible state
  output logic [tw_pkg::ADDR_W-1:0]       table_pointer,
  output logic [tw_pkg::WORD_W-1:0]       table_latch,
  output logic                            prog_fail
);
  import tw_pkg::*;

  // =====================================================
  // Helpers
  function automatic logic is_internal(input logic [ADDR_W-1:0] a);
    return a < INT_LIMIT;
  endfunction

  function automatic logic [WORD_W-1:0] merge_byte(input logic [WORD_W-1:0] w,
                                                   input logic hi, input logic [DATA_W-1:0] b);
    return hi ? {b, w[DATA_W-1:0]} : {w[WORD_W-1:DATA_W], b};
  endfunction

  // =====================================================
  // Declarations
  tw_phase_type              phase;
  tw_state_type              state_q;
  tw_instr_type              instr_q;
  logic [DATA_W-1:0]         fdata_q;
  logic [ADDR_W-1:0]         ptr_q;
  logic [WORD_W-1:0]         latch_q;
  logic [PROG_CNT_W-1:0]     prog_cnt_q;
  tw_pm_req_type             pm_q;
  logic                      done_q;
  logic                      fail_q;
  logic                      file_rd_q;
  logic                      start;
  logic                      prog_end;

  tw_phase_gen u_phase (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .phase   (phase)
  );

  // Instruction accepted only at Q1 while idle
  assign instr_ready = (state_q == TW_IDLE) && (phase == TW_Q1);
  assign start       = instr_valid && instr_ready;
  assign prog_end    = (state_q == TW_PROG) && (phase == TW_Q4)
                       && ((prog_cnt_q == '0) || irq_abort);
  assign busy        = (state_q != TW_IDLE);

  // =====================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= TW_IDLE;
    end else begin
      case (state_q)
        TW_IDLE: if (start) state_q <= TW_CYC1;
        // Second instruction cycle holds the write, or the long on-chip pulse
        TW_CYC1: if (phase == TW_Q4) state_q <= TW_CYC2;                       // [RL3]
        TW_CYC2: begin
          if (phase == TW_Q4) begin
            state_q <= pm_q.internal ? TW_PROG : TW_IDLE;                      // [RL3]
          end
        end
        TW_PROG: if (prog_end) state_q <= TW_IDLE;
        default: state_q <= TW_IDLE;
      endcase
    end
  end

  // =====================================================
  // Capture instruction fields at issue
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_q <= '0;
    end else if (start) begin
      instr_q <= instr;
    end
  end

  // =====================================================
  // File register read in Q2 of the first cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_rd_q <= 1'b0;
      fdata_q   <= '0;
    end else begin
      // Pulse in Q2, the cycle right after the Q1 take edge
      file_rd_q <= start;                                                       // [RL5]
      if (file_rd_q) begin
        fdata_q <= file_data;                                                   // [RL5]
      end
    end
  end

  assign file_rd   = file_rd_q;
  assign file_addr = instr_q.file_addr;

  // =====================================================
  // Latch half update in Q3 (execute)
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= LATCH_RST;
    end else if ((state_q == TW_CYC1) && (phase == TW_Q3)) begin
      latch_q <= merge_byte(latch_q, instr_q.high_sel, fdata_q);               // [RL6] [RL5]
    end
  end

  // =====================================================
  // Program memory write issued in Q4 of the first cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_q <= '0;
    end else if ((state_q == TW_CYC1) && (phase == TW_Q4)) begin
      pm_q.strobe   <= 1'b1;                                                    // [RL5]
      pm_q.internal <= is_internal(ptr_q);
      pm_q.prog_ok  <= prog_voltage_ok;                                         // [RL4]
      pm_q.addr     <= ptr_q;
      pm_q.data     <= latch_q;
    end else begin
      pm_q.strobe <= 1'b0;
    end
  end

  assign pm_req      = pm_q;
  assign prog_active = (state_q == TW_PROG);

  // =====================================================
  // Programming pulse length; interrupt cuts it short
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_cnt_q <= '0;
    end else if ((state_q == TW_CYC2) && (phase == TW_Q4)) begin
      prog_cnt_q <= PROG_CNT_W'(PROG_LEN);                                      // [RL3]
    end else if ((state_q == TW_PROG) && (prog_cnt_q != '0)) begin
      prog_cnt_q <= prog_cnt_q - 1'b1;
    end
  end

  // =====================================================
  // Failure flag: sequence ran without programming voltage or was cut short
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fail_q <= 1'b0;
    end else if (start) begin
      fail_q <= 1'b0;
    end else if (prog_end) begin
      fail_q <= !pm_q.prog_ok || (prog_cnt_q != '0);                            // [RL4]
    end
  end

  assign prog_fail = fail_q;

  // =====================================================
  // Pointer update once the write has completed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= PTR_RST;
    end else if (((state_q == TW_CYC2) && (phase == TW_Q4) && !pm_q.internal) || prog_end) begin
      if (instr_q.inc) begin
        ptr_q <= ptr_q + PTR_STEP;                                              // [RL2]
      end else begin
        ptr_q <= ptr_q;                                                         // [RL1]
      end
    end
  end

  // =====================================================
  // Completion pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= ((state_q == TW_CYC2) && (phase == TW_Q4) && !pm_q.internal) || prog_end;
    end
  end

  assign done          = done_q;
  assign table_pointer = ptr_q;
  assign table_latch   = latch_q;

endmodule

// File: logic/tw_phase_gen.sv
// Quarter-phase generator for the instruction cycle
`timescale 1ns/1ps
module tw_phase_gen (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Phase output
  output tw_pkg::tw_phase_type      phase
);
  import tw_pkg::*;

  tw_phase_type phase_q;

  // =====================================================
  // Phase rotation, Q1 first after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= TW_Q1;
    end else begin
      case (phase_q)
        TW_Q1:   phase_q <= TW_Q2;
        TW_Q2:   phase_q <= TW_Q3;
        TW_Q3:   phase_q <= TW_Q4;
        TW_Q4:   phase_q <= TW_Q1;
        default: phase_q <= TW_Q1;
      endcase
    end
  end

  assign phase = phase_q;

endmodule

// File: logic/tw_pkg.sv
// Shared constants and carrier types for the table-write execution block
package tw_pkg;

  // =====================================================
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 16;

  // =====================================================
  // Reset values and pointer step
  localparam logic [ADDR_W-1:0] PTR_RST   = 16'h0000;
  localparam logic [WORD_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] PTR_STEP  = 16'h0001;

  // =====================================================
  // Timing: on-chip programming pulse length
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned PROG_TIME_NS   = 1000;
  localparam int unsigned PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W     = 16;
  // Default top of on-chip program space (first external address)
  localparam logic [ADDR_W-1:0] INT_LIMIT = 16'h2000;

  // =====================================================
  // Quarter phases of an instruction cycle, one-hot
  typedef enum logic [3:0] {
    TW_Q1 = 4'h1,
    TW_Q2 = 4'h2,
    TW_Q3 = 4'h4,
    TW_Q4 = 4'h8
  } tw_phase_type;

  // Execution states, one-hot
  typedef enum logic [3:0] {
    TW_IDLE  = 4'h1,
    TW_CYC1  = 4'h2,
    TW_CYC2  = 4'h4,
    TW_PROG  = 4'h8
  } tw_state_type;

  // Decoded instruction fields
  typedef struct packed {
    logic              high_sel;   // byte-select bit
    logic              inc;        // increment option bit
    logic [DATA_W-1:0] file_addr;  // source file register
  } tw_instr_type;

  // Program memory write request
  typedef struct packed {
    logic              strobe;
    logic              internal;
    logic              prog_ok;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } tw_pm_req_type;

endpackage

// File: test/testbench.sv
// Self-checking bench for the table-write execution block
`timescale 1ns/1ps
module testbench;
  import tw_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst_b, instr_valid, prog_voltage_ok, irq_abort;
  tw_instr_type  instr;
  logic [7:0]    file_data, wr_cnt;
  logic          instr_ready, busy, done, prog_fail;
  tw_pm_req_type pm_req;
  logic [15:0]   table_pointer, table_latch, mem_q, addr_q;
  logic          file_rd, prog_active;
  logic [7:0]    file_addr;
  int            rd_cnt = 0;
  int            act_cnt = 0;
  int            bad_count = 0;
  int            cmp_count = 0;
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  // =====================================================
  // Design, short programming pulse long enough that an abort cuts it, and memory model
  tw_exec #(.PROG_LEN(7)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .busy(busy), .done(done), .file_rd(file_rd),
    .file_addr(file_addr), .file_data(file_data), .prog_voltage_ok(prog_voltage_ok),
    .irq_abort(irq_abort), .pm_req(pm_req), .prog_active(prog_active),
    .table_pointer(table_pointer), .table_latch(table_latch), .prog_fail(prog_fail));
  // Count read pulses and programming cycles as the clock edge sees them
  always @(posedge sys_clk) begin
    if (file_rd === 1'b1) rd_cnt++;
    if (prog_active === 1'b1) act_cnt++;
  end
  tw_pm_model u_pm (.sys_clk(sys_clk), .rst_b(rst_b), .pm_req(pm_req), .mem_q(mem_q),
    .addr_q(addr_q), .wr_cnt_q(wr_cnt));
  // =====================================================
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Valid stays up for 3 more rising edges past the take to prove a busy block refuses it
  task automatic run_op(input logic hi, input logic inc, input logic [7:0] fd, output int n);
    file_data = fd;
    instr = '{high_sel: hi, inc: inc, file_addr: 8'h3C};
    instr_valid = 1'b1;
    n = 0;
    repeat (8) if (instr_ready !== 1'b1) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    instr_valid = 1'b0;
    n = 4;
    while (done !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
  endtask
  // =====================================================
  task automatic t_low_keep;
    int n;
    run_op(1'b0, 1'b0, 8'h53, n);
    check("latch", table_latch, 16'h0053);
    check("pointer", table_pointer, 16'h0000);
    check("mem", mem_q, 16'h0053);
    check("many cycles", 16'(n > 8), 16'h0001);
    check("file reads", 16'(rd_cnt), 16'h0001);
    check("file addr", 16'(file_addr), 16'h003C);
    check("prog cycles", 16'(act_cnt), 16'h0008);
  endtask
  task automatic t_no_volt;
    int n;
    prog_voltage_ok = 1'b0;
    run_op(1'b0, 1'b0, 8'h11, n);
    check("fail flag", 16'(prog_fail), 16'h0001);
    check("writes", 16'(wr_cnt), 16'h0002);
    check("mem kept", mem_q, 16'h0053);
    prog_voltage_ok = 1'b1;
  endtask
  task automatic t_high_inc;
    int n;
    run_op(1'b1, 1'b1, 8'hAA, n);
    check("latch", table_latch, 16'hAA11);
    check("pointer", table_pointer, 16'h0001);
    check("addr", addr_q, 16'h0000);
    check("mem", mem_q, 16'hAA11);
    check("fail flag", 16'(prog_fail), 16'h0000);
  endtask
  task automatic t_abort;
    int n;
    int a0;
    a0 = act_cnt;
    irq_abort = 1'b1;
    run_op(1'b0, 1'b0, 8'h77, n);
    check("fail flag", 16'(prog_fail), 16'h0001);
    check("abort cycles", 16'(act_cnt - a0), 16'h0004);
    check("pointer", table_pointer, 16'h0001);
    irq_abort = 1'b0;
  endtask
  // =====================================================
  initial begin
    {rst_b, instr_valid, irq_abort, instr, file_data} = '0;
    prog_voltage_ok = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    t_low_keep();
    t_no_volt();
    t_high_inc();
    t_abort();
    end_of_test();
  end
  // Watchdog: four operations need under a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
endmodule

// File: test/tw_exec_properties.sv
// Checker for table-write timing, latch merge and pointer update
`timescale 1ns/1ps
module tw_exec_properties #(
  parameter int unsigned PROG_LEN = 3
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  // Observed ports
  input wire logic                 instr_valid,
  input wire tw_pkg::tw_instr_type instr,
  input wire logic                 instr_ready,
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic                 file_rd,
  input wire logic [7:0]           file_data,
  input wire logic                 prog_voltage_ok,
  input wire tw_pkg::tw_pm_req_type pm_req,
  input wire logic [15:0]          table_pointer,
  input wire logic [15:0]          table_latch,
  input wire logic                 prog_fail
);
  import tw_pkg::*;
  logic        take;
  logic [15:0] ptr_q;
  logic [15:0] lat_q;
  logic [7:0]  fd_q;
  logic        inc_q;
  logic        hi_q;
  logic        int_q;
  logic        vok_q;
  assign take = instr_valid && instr_ready;
  // =====================================================
  // Operand snapshots, so later checks need no $past depth
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {ptr_q, lat_q, inc_q, hi_q, int_q, vok_q} <= '0;
    end else if (take) begin
      {ptr_q, lat_q} <= {table_pointer, table_latch};
      {inc_q, hi_q, vok_q} <= {instr.inc, instr.high_sel, prog_voltage_ok};
      int_q <= table_pointer < INT_LIMIT;
    end
  end
  // File byte as the block samples it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fd_q <= '0;
    end else if (file_rd) begin
      fd_q <= file_data;
    end
  end
  // =====================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_READ_AFTER_TAKE: assert property (take |=> file_rd) else $error("no file read after take");
  AST_READ_PULSE: assert property (file_rd |=> !file_rd) else $error("file read too long");
  AST_DONE_PULSE: assert property (done |=> !done) else $error("done too long");
  AST_BUSY_REFUSE: assert property (busy |-> !instr_ready) else $error("ready while busy");
  AST_DONE_BOUND: assert property (take |-> ##[7:1000] done) else $error("done missing");
  AST_ONCHIP_LONG: assert property (take && table_pointer < INT_LIMIT |=> !done [*8])
    else $error("on-chip write too short");
  AST_PTR_KEEP: assert property (done && !inc_q |-> table_pointer == ptr_q) else $error("pointer moved");
  AST_PTR_INC: assert property (done && inc_q |-> table_pointer == ptr_q + 16'h0001)
    else $error("pointer not advanced");
  AST_MERGE: assert property (pm_req.strobe |-> pm_req.data == (hi_q ? {fd_q, lat_q[7:0]} : {lat_q[15:8], fd_q}))
    else $error("written word wrong");
  AST_NO_VOLT_FAIL: assert property (done && int_q && !vok_q |-> ##[0:1] prog_fail)
    else $error("failure not flagged");
endmodule

bind tw_exec tw_exec_properties #(.PROG_LEN(PROG_LEN)) u_props (.*);

// File: test/tw_pm_model.sv
// Program memory model on the far side of the table-write block
`timescale 1ns/1ps
module tw_pm_model (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  // Write request
  input wire tw_pkg::tw_pm_req_type pm_req,
  // Observation
  output logic [15:0]               mem_q,
  output logic [15:0]               addr_q,
  output logic [7:0]                wr_cnt_q
);
  import tw_pkg::*;
  // One stored word; a pulse without voltage to an on-chip address is counted but stores nothing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {mem_q, addr_q, wr_cnt_q} <= '0;
    end else if (pm_req.strobe) begin
      wr_cnt_q <= wr_cnt_q + 8'h01;
      addr_q <= pm_req.addr;
      if (pm_req.prog_ok || !pm_req.internal) mem_q <= pm_req.data;
    end
  end
endmodule
